// ===== src/dpc_pkg.sv
package dpc_pkg;

	// ===========================================================
	// widths
	localparam int DPC_ADDR_W  = 13;
	localparam int DPC_DATA_W  = 16;
	localparam int DPC_LATCH_W = 3;

	// ===========================================================
	// timing, ns and derived cycles at 40 MHz
	localparam int DPC_CLK_PS       = 25000;
	localparam int DPC_T_ACC_NS     = 55;   // slowest grade access
	localparam int DPC_T_PWE_NS     = 45;   // write pulse allowance
	localparam int DPC_T_SOP_NS     = 20;   // semaphore update pulse
	localparam int DPC_T_SWRD_NS    = 15;   // semaphore write to read
	localparam int DPC_T_WH_NS      = 40;   // r/w high after busy high
	localparam int DPC_ACC_CYC  = (DPC_T_ACC_NS * 1000 + DPC_CLK_PS - 1) / DPC_CLK_PS;
	localparam int DPC_PWE_CYC  = (DPC_T_PWE_NS * 1000 + DPC_CLK_PS - 1) / DPC_CLK_PS;
	localparam int DPC_SOP_CYC  = (DPC_T_SOP_NS * 1000 + DPC_CLK_PS - 1) / DPC_CLK_PS;
	localparam int DPC_SWRD_CYC = (DPC_T_SWRD_NS * 1000 + DPC_CLK_PS - 1) / DPC_CLK_PS;
	localparam int DPC_WH_CYC   = (DPC_T_WH_NS * 1000 + DPC_CLK_PS - 1) / DPC_CLK_PS;
	localparam int DPC_CNT_W    = 4;

	// ===========================================================
	// semaphore data bit values
	localparam logic DPC_LATCH_TAKE = 1'b0;
	localparam logic DPC_LATCH_FREE = 1'b1;

	// ===========================================================
	// user commands
	typedef enum logic [1:0]
	{
		DPC_CMD_RD     = 2'b00,
		DPC_CMD_WR     = 2'b01,
		DPC_CMD_SEMREQ = 2'b10,
		DPC_CMD_SEMREL = 2'b11
	} dpc_cmd_t;

	typedef struct packed
	{
		dpc_cmd_t              cmd;
		logic [DPC_ADDR_W-1:0] addr;
		logic [DPC_DATA_W-1:0] wdata;
		logic [1:0]            byteEn; // [1] upper, [0] lower
	} dpc_req_t;

	typedef struct packed
	{
		logic [DPC_DATA_W-1:0] rdata;
		logic                  latchOwned;
		logic                  busyHit;
	} dpc_rsp_t;

	// port pins driven toward the device, active low except addr and rw
	typedef struct packed
	{
		logic [DPC_ADDR_W-1:0] addr;
		logic                  portSelect_n;
		logic                  readWrite;
		logic                  outputEnable_n;
		logic                  upper_byte_select_n;
		logic                  lower_byte_select_n;
		logic                  semaphore_select_n;
	} dpc_pins_t;

endpackage : dpc_pkg

// ===== src/dpc_wait_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// counts down a loaded number of cycles; done is high when zero
module dpc_wait_cnt
	import dpc_pkg::*;
#(
	parameter int W = DPC_CNT_W
)
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// control
	input  wire logic         load,
	input  wire logic [W-1:0] loadVal,
	output logic              done
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// ===========================================================
	// next count
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (load)
			cnt_nxt = loadVal;
		else if (cnt_r != '0)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign done = (cnt_r == '0);

endmodule : dpc_wait_cnt
`default_nettype wire

// ===== src/dpc_port_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// controller for one port of the dual-port memory: array reads and writes,
// semaphore request and release, busy-aware write timing, retention hold
module dpc_port_ctrl
	import dpc_pkg::*;
(
	// clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// user request
	input  wire logic                  reqValid,
	input  wire dpc_req_t              req,
	output logic                       reqReady,
	output logic                       rspValid,
	output dpc_rsp_t                   rsp,
	// retention hold request
	input  wire logic                  retainHold,
	// device pins
	output dpc_pins_t                  pins,
	input  wire logic [DPC_DATA_W-1:0] dataIn,
	output logic [DPC_DATA_W-1:0]      dataOut,
	output logic                       dataOe_n,
	input  wire logic                  busyIn_n
);

	// ===========================================================
	// state machine
	typedef enum logic [2:0]
	{
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD   = 3'b011,
		ST_GAP    = 3'b100,
		ST_SEMRD  = 3'b101,
		ST_DONE   = 3'b110
	} dpc_state_t;

	dpc_state_t            state_r,   state_nxt;
	dpc_req_t              cur_r,     cur_nxt;
	dpc_pins_t             pins_r,    pins_nxt;
	logic [DPC_DATA_W-1:0] dout_r,    dout_nxt;
	logic                  oeN_r,     oeN_nxt;
	dpc_rsp_t              rsp_r,     rsp_nxt;
	logic                  rspV_r,    rspV_nxt;
	logic                  busySeen_r, busySeen_nxt;
	logic                  cntLoad;
	logic [DPC_CNT_W-1:0]  cntVal;
	logic                  cntDone;
	logic                  isWrite;
	logic                  isLatch;

	dpc_wait_cnt #(.W(DPC_CNT_W)) u_wait
	(
		.mclk    (mclk),
		.rst     (rst),
		.load    (cntLoad),
		.loadVal (cntVal),
		.done    (cntDone)
	);

	assign isWrite  = (cur_r.cmd != DPC_CMD_RD);
	assign isLatch  = cur_r.cmd[1];
	assign reqReady = (state_r == ST_IDLE) && !retainHold;

	// ===========================================================
	// next-state and pin sequencing
	always_comb
	begin
		state_nxt    = state_r;
		cur_nxt      = cur_r;
		pins_nxt     = pins_r;
		dout_nxt     = dout_r;
		oeN_nxt      = oeN_r;
		rsp_nxt      = rsp_r;
		rspV_nxt     = 1'b0;
		busySeen_nxt = busySeen_r;
		cntLoad      = 1'b0;
		cntVal       = '0;
		unique case (state_r)
			ST_IDLE:
			begin
				// idle: port and semaphore selects high, byte selects unchanged, r/w high, pins released
				pins_nxt.portSelect_n       = 1'b1;
				pins_nxt.semaphore_select_n = 1'b1;
				pins_nxt.readWrite          = 1'b1;
				pins_nxt.outputEnable_n     = 1'b1;
				oeN_nxt                     = 1'b1;
				if (reqValid && !retainHold)
				begin
					cur_nxt      = req;
					busySeen_nxt = 1'b0;
					// address moves only while r/w is high
					pins_nxt.addr = req.addr;
					if (req.cmd[1])
					begin
						// semaphore: byte selects ignored, lower held low for the write strobe
						pins_nxt.addr                = {{(DPC_ADDR_W-DPC_LATCH_W){1'b0}}, req.addr[DPC_LATCH_W-1:0]};
						pins_nxt.upper_byte_select_n = 1'b1;
						pins_nxt.lower_byte_select_n = 1'b0;
						dout_nxt = {{(DPC_DATA_W-1){1'b1}},
							(req.cmd == DPC_CMD_SEMREQ) ? DPC_LATCH_TAKE : DPC_LATCH_FREE};
					end
					else
					begin
						pins_nxt.upper_byte_select_n = !req.byteEn[1];
						pins_nxt.lower_byte_select_n = !req.byteEn[0];
						dout_nxt = req.wdata;
					end
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				// select and r/w fall on one edge, so the device keeps its outputs quiet for a write
				if (isLatch)
				begin
					pins_nxt.portSelect_n       = 1'b1;
					pins_nxt.semaphore_select_n = 1'b0;
				end
				else
				begin
					pins_nxt.portSelect_n       = 1'b0;
					pins_nxt.semaphore_select_n = 1'b1;
				end
				pins_nxt.outputEnable_n = isWrite;
				state_nxt = ST_STROBE;
				cntLoad   = 1'b1;
				cntVal    = isWrite ? DPC_CNT_W'(DPC_PWE_CYC) : DPC_CNT_W'(DPC_ACC_CYC);
				if (isWrite)
				begin
					pins_nxt.readWrite = 1'b0;
					// we drive only once the device output enable is off
					oeN_nxt = 1'b0;
				end
			end
			ST_STROBE:
			begin
				if (!busyIn_n)
					busySeen_nxt = 1'b1;
				// an array write under busy is stretched until busy rises; semaphore writes are not
				if (cntDone && (busyIn_n || !isWrite || isLatch))
				begin
					if (!isWrite)
						rsp_nxt.rdata = dataIn;
					pins_nxt.readWrite = 1'b1;
					state_nxt = ST_HOLD;
					cntLoad   = 1'b1;
					cntVal    = busySeen_r ? DPC_CNT_W'(DPC_WH_CYC) : DPC_CNT_W'(1);
				end
			end
			ST_HOLD:
			begin
				// deselect and release the data bus on the same edge
				pins_nxt.portSelect_n       = 1'b1;
				pins_nxt.semaphore_select_n = 1'b1;
				pins_nxt.outputEnable_n     = 1'b1;
				oeN_nxt                     = 1'b1;
				if (cntDone)
				begin
					state_nxt = ST_GAP;
					cntLoad   = 1'b1;
					cntVal    = isLatch ? DPC_CNT_W'(DPC_SWRD_CYC) : DPC_CNT_W'(DPC_SOP_CYC);
				end
			end
			ST_GAP:
			begin
				if (cntDone)
				begin
					if (isLatch)
					begin
						// read back the latch to learn the arbitration outcome
						pins_nxt.semaphore_select_n = 1'b0;
						pins_nxt.outputEnable_n     = 1'b0;
						state_nxt = ST_SEMRD;
						cntLoad   = 1'b1;
						cntVal    = DPC_CNT_W'(DPC_ACC_CYC);
					end
					else
						state_nxt = ST_DONE;
				end
			end
			ST_SEMRD:
			begin
				if (cntDone)
				begin
					rsp_nxt.rdata    = dataIn;
					rsp_nxt.latchOwned = (dataIn[0] == DPC_LATCH_TAKE);
					pins_nxt.semaphore_select_n = 1'b1;
					pins_nxt.outputEnable_n     = 1'b1;
					state_nxt = ST_DONE;
				end
			end
			ST_DONE:
			begin
				rsp_nxt.busyHit = busySeen_r;
				if (!isLatch)
					rsp_nxt.latchOwned = 1'b0;
				rspV_nxt  = 1'b1;
				state_nxt = ST_IDLE;
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// ===========================================================
	// registers; reset leaves both selects high
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r    <= ST_IDLE;
			cur_r      <= '0;
			pins_r     <= '{addr: '0, portSelect_n: 1'b1, readWrite: 1'b1, outputEnable_n: 1'b1,
				upper_byte_select_n: 1'b1, lower_byte_select_n: 1'b1, semaphore_select_n: 1'b1};
			dout_r     <= '0;
			oeN_r      <= 1'b1;
			rsp_r      <= '0;
			rspV_r     <= 1'b0;
			busySeen_r <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			cur_r      <= cur_nxt;
			pins_r     <= pins_nxt;
			dout_r     <= dout_nxt;
			oeN_r      <= oeN_nxt;
			rsp_r      <= rsp_nxt;
			rspV_r     <= rspV_nxt;
			busySeen_r <= busySeen_nxt;
		end
	end

	assign pins     = pins_r;
	assign dataOut  = dout_r;
	assign dataOe_n = oeN_r;
	assign rsp      = rsp_r;
	assign rspValid = rspV_r;

endmodule : dpc_port_ctrl
`default_nettype wire

// ===== tb/dpc_port_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// pin rules at the controller outputs
module dpc_port_ctrl_assertions
	import dpc_pkg::*;
(
	// clock and reset
	input	wire logic				mclk,
	input	wire logic				rst,
	// user side
	input	wire logic				reqValid,
	input	wire dpc_req_t			req,
	input	wire logic				reqReady,
	input	wire logic				rspValid,
	input	wire dpc_rsp_t			rsp,
	input	wire logic				retainHold,
	// device side
	input	wire dpc_pins_t			pins,
	input	wire logic [DPC_DATA_W-1:0]	dataIn,
	input	wire logic [DPC_DATA_W-1:0]	dataOut,
	input	wire logic				dataOe_n,
	input	wire logic				busyIn_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// array and semaphore selects never together
	property p_selx; !(!pins.portSelect_n && !pins.semaphore_select_n); endproperty
	a_selx: assert property (p_selx) else $error("both selects low");
	property p_bytes; !pins.portSelect_n |-> !(pins.upper_byte_select_n && pins.lower_byte_select_n); endproperty
	a_bytes: assert property (p_bytes) else $error("array select without byte lane");
	property p_addr; pins.addr != $past(pins.addr) |-> pins.readWrite && $past(pins.readWrite); endproperty
	a_addr: assert property (p_addr) else $error("address moved during write");
	property p_wdrv; !pins.readWrite && !(pins.portSelect_n && pins.semaphore_select_n) |-> !dataOe_n; endproperty
	a_wdrv: assert property (p_wdrv) else $error("write strobe without data");
	// both sides driving the data lines would fight
	property p_clash; !dataOe_n |-> pins.outputEnable_n; endproperty
	a_clash: assert property (p_clash) else $error("data driven with output enable");
	property p_oe; !pins.outputEnable_n |-> pins.readWrite; endproperty
	a_oe: assert property (p_oe) else $error("output enable during write");
	property p_busy; !busyIn_n && !pins.readWrite && !pins.portSelect_n |=> !pins.readWrite; endproperty
	a_busy: assert property (p_busy) else $error("write ended while busy");
	// once deselected under retention the port stays deselected and takes nothing
	property p_ret; retainHold && $past(retainHold) && $past(retainHold, 2) && $past(pins.portSelect_n)
		|-> pins.portSelect_n && !reqReady; endproperty
	a_ret: assert property (p_ret) else $error("ready during retention");
	property p_done; reqValid && reqReady |-> ##[4:60] rspValid ##1 !rspValid; endproperty
	a_done: assert property (p_done) else $error("no single response");
endmodule : dpc_port_ctrl_assertions

bind dpc_port_ctrl dpc_port_ctrl_assertions dpc_port_ctrl_assertions_i (.mclk(mclk), .rst(rst),
	.reqValid(reqValid), .req(req), .reqReady(reqReady), .rspValid(rspValid), .rsp(rsp),
	.retainHold(retainHold), .pins(pins), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
	.busyIn_n(busyIn_n));
`default_nettype wire

// ===== tb/dpc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// one port of the memory device; far port only shown as owned latches
module dpc_dev_model
	import dpc_pkg::*;
(
	// clock
	input	wire logic				mclk,
	// controller pins
	input	wire dpc_pins_t			pins,
	input	wire logic [DPC_DATA_W-1:0]	dataOut,
	input	wire logic				dataOe_n,
	input	wire logic				busyIn_n,
	output	logic [DPC_DATA_W-1:0]		dataIn,
	// latches held by the far port
	input	wire logic [7:0]			otherOwns
);
	logic [DPC_DATA_W-1:0]	mem [0:8191];
	logic [DPC_DATA_W-1:0]	last = '0;
	logic [7:0]		latchOurs = 8'h00;
	logic			arr, lat, wr, drv;
	logic [2:0]		s;

	// decode; array needs a byte lane
	assign arr = !pins.portSelect_n && pins.semaphore_select_n
		&& !(pins.upper_byte_select_n && pins.lower_byte_select_n);
	assign lat = pins.portSelect_n && !pins.semaphore_select_n;
	assign wr = (arr || lat) && !pins.readWrite;
	assign drv = (arr || lat) && pins.readWrite && !pins.outputEnable_n;
	assign s = pins.addr[2:0];
	// released lines toggle so a stale value never passes
	assign dataIn = (drv && !dataOe_n) ? 'x : !dataOe_n ? dataOut : !drv ? ~last
		: lat ? {15'h7fff, !latchOurs[s]} : mem[pins.addr];

	// writes land on the clock while the strobe is low
	always @(posedge mclk)
	begin
		last <= dataIn;
		if (wr && arr && busyIn_n)
		begin
			if (!pins.lower_byte_select_n)
				mem[pins.addr][7:0] <= dataIn[7:0];
			if (!pins.upper_byte_select_n)
				mem[pins.addr][15:8] <= dataIn[15:8];
		end
		if (wr && lat)
			latchOurs[s] <= dataIn[0] ? 1'b0 : (latchOurs[s] || !otherOwns[s]);
	end
endmodule : dpc_dev_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// self-checking bench for one port controller
module testbench
	import dpc_pkg::*;
;
	logic				mclk, rst, reqValid, reqReady, rspValid, retainHold, dataOe_n, busyIn_n;
	dpc_req_t			req;
	dpc_rsp_t			rsp;
	dpc_pins_t			pins;
	logic [DPC_DATA_W-1:0]	dataIn, dataOut;
	logic [7:0]			otherOwns;
	int				num_errors = 0, num_checks = 0, cycles = 0;

	dpc_port_ctrl dpc_port_ctrl_i (.mclk(mclk), .rst(rst), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .rspValid(rspValid), .rsp(rsp), .retainHold(retainHold), .pins(pins),
		.dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n), .busyIn_n(busyIn_n));
	dpc_dev_model dpc_dev_model_i (.mclk(mclk), .pins(pins), .dataOut(dataOut), .dataOe_n(dataOe_n),
		.busyIn_n(busyIn_n), .dataIn(dataIn), .otherOwns(otherOwns));

	// ==========
	// clock and hang guard
	always #12.5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	// one request, held until taken, then wait for the answer
	task automatic op(input dpc_cmd_t c, input logic [12:0] a, input logic [15:0] d, input logic [1:0] be);
		int n;
		n = 0;
		@(negedge mclk);
		req = '{c, a, d, be};
		reqValid = 1'b1;
		while (reqReady !== 1'b1 && n < 100)
		begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		reqValid = 1'b0;
		while (rspValid !== 1'b1 && n < 200)
		begin
			@(negedge mclk);
			n++;
		end
		check("answer", rspValid, 1'b1);
	endtask : op

	task automatic t_lanes();
		op(DPC_CMD_WR, 13'h5, 16'h1234, 2'b11);
		op(DPC_CMD_WR, 13'h5, 16'habcd, 2'b01);
		op(DPC_CMD_WR, 13'h6, 16'h0f0f, 2'b10);
		op(DPC_CMD_RD, 13'h5, 16'h0, 2'b11);
		check("lane", rsp.rdata, 16'h12cd);
		check("noBusy", rsp.busyHit, 1'b0);
	endtask : t_lanes

	// busy low must stretch the write until it lifts
	task automatic t_busy();
		busyIn_n = 1'b0;
		fork
			op(DPC_CMD_WR, 13'h5, 16'h5555, 2'b11);
			begin
				repeat (8) @(negedge mclk);
				busyIn_n = 1'b1;
			end
		join
		check("busyHit", rsp.busyHit, 1'b1);
	endtask : t_busy

	// far port holds latch 3, all others are free from start
	task automatic t_sem();
		otherOwns = 8'h08;
		for (int i = 0; i < 8; i++)
		begin
			op(DPC_CMD_SEMREQ, 13'(i), 16'h0, 2'b11);
			check("own", rsp.latchOwned, i != 3);
		end
		op(DPC_CMD_SEMREL, 13'h2, 16'h1, 2'b11);
		check("free", rsp.latchOwned, 1'b0);
	endtask : t_sem

	task automatic t_retain();
		retainHold = 1'b1;
		fork
			op(DPC_CMD_RD, 13'h5, 16'h0, 2'b11);
			begin
				repeat (10)
				begin
					@(negedge mclk);
					check("hold", {reqReady, pins.portSelect_n, pins.semaphore_select_n}, 3'b011);
				end
				retainHold = 1'b0;
			end
		join
		check("rdata", rsp.rdata, 16'h5555);
	endtask : t_retain

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	initial
	begin
		mclk = 1'b0;
		rst = 1'b1;
		reqValid = 1'b0;
		req = '0;
		retainHold = 1'b0;
		busyIn_n = 1'b1;
		otherOwns = 8'h00;
		repeat (20) @(negedge mclk);
		check("idle", {pins.portSelect_n, pins.semaphore_select_n, pins.readWrite, dataOe_n}, 4'hf);
		rst = 1'b0;
		t_lanes();
		t_busy();
		t_sem();
		t_retain();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
